// [erfp_pkg.sv]
// Package for the per-port error-management and fail-policy block.
// Assumes a single 250 MHz clock domain and a plain word register port.
package erfp_pkg;
	localparam int ERFP_NUM_PORTS = 16;
	localparam int ERFP_ADDR_W = 16;
	localparam int ERFP_DATA_W = 32;
	localparam int ERFP_CNT_W = 8;
	localparam int ERFP_QCNT_W = 8;
	// Address map
	localparam logic [15:0] ERFP_GEN_BASE = 16'h1000;
	localparam logic [15:0] ERFP_GEN_HEADER = 16'h1000;
	localparam logic [15:0] ERFP_PORT_BASE = 16'h1040;
	localparam logic [15:0] ERFP_PORT_LAST = 16'h1400;
	localparam logic [15:0] ERFP_PORT_STRIDE = 16'h0040;
	// Offsets inside one port block
	localparam logic [5:0] ERFP_OFS_DETECT = 6'h08;
	localparam logic [5:0] ERFP_OFS_CAPTURE = 6'h0c;
	localparam logic [5:0] ERFP_OFS_STATUS = 6'h18;
	localparam logic [5:0] ERFP_OFS_RATE = 6'h28;
	// Block-local control registers
	localparam logic [15:0] ERFP_IRQ_STAT = 16'h1800;
	localparam logic [15:0] ERFP_IRQ_MASK = 16'h1804;
	localparam logic [15:0] ERFP_PDOWN = 16'h1808;
	// Header value
	localparam logic [15:0] ERFP_FEATURE_ID = 16'h0007;
	localparam logic [15:0] ERFP_NEXT_PTR = 16'h0000;
	// Detect and status register bit positions
	localparam int ERFP_BIT_DETECT = 0;
	localparam int ERFP_BIT_OUT_FAILED = 24;
	localparam int ERFP_BIT_OUT_DROPPED = 26;
	localparam int ERFP_BIT_STOP_FAIL = 28;
	localparam int ERFP_BIT_DROP_EN = 29;
	localparam int ERFP_BIT_WIDE_PORT = 31;
	// Rate register fields
	localparam int ERFP_RATE_CNT_LSB = 0;
	localparam int ERFP_RATE_THR_LSB = 16;
	// Reset values
	localparam logic [7:0] ERFP_RST_THRESHOLD = 8'hff;
	localparam logic [31:0] ERFP_RST_ZERO = 32'h0000_0000;
endpackage : erfp_pkg

// [erfp_port.sv]
// One port's fail policy: packet dispatch decision under counter threshold.
// Assumes queue events come from the same clock domain as the registers.
module erfp_port
	import erfp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic ce,
	input wire logic rst,
	// Policy bits and state
	input wire logic stop_fail_en,
	input wire logic drop_en,
	input wire logic output_failed,
	input wire logic threshold_hit,
	// Queue events
	input wire logic pkt_enq,
	input wire logic pkt_head,
	input wire logic pkt_nack,
	// Decisions
	output logic tx_allow,
	output logic drop_pulse
);
	logic [ERFP_QCNT_W-1:0] flush_left;
	logic [ERFP_QCNT_W-1:0] queued;
	logic both_mode;
	logic both_prev;

	assign both_mode = stop_fail_en && drop_en && output_failed;

	// Onset marker kept under the enable so a frozen cycle cannot hide the onset
	always_ff @(posedge clk) begin
		if (rst)
			both_prev <= 1'b0;
		else if (ce)
			both_prev <= both_mode;
	end

	// Queue occupancy so the flush covers only packets held at failure
	always_ff @(posedge clk) begin
		if (rst)
			queued <= '0;
		else if (ce)
			queued <= queued + ERFP_QCNT_W'(pkt_enq) - ERFP_QCNT_W'(pkt_head && queued != 0);
	end

	always_ff @(posedge clk) begin
		if (rst || !both_mode)
			flush_left <= '0;
		else if (ce) begin
			if (flush_left == 0 && !both_prev)
				flush_left <= queued;
			else if (pkt_head && flush_left != 0)
				flush_left <= flush_left - 1'b1;
		end
	end

	always_comb begin
		tx_allow = 1'b1;
		drop_pulse = 1'b0;
		if (both_mode && flush_left != 0) begin
			tx_allow = 1'b0;
			drop_pulse = pkt_head;
		end else if (stop_fail_en && !drop_en && output_failed) begin
			tx_allow = 1'b0;
		end else if (drop_en && !stop_fail_en && threshold_hit) begin
			drop_pulse = pkt_nack;
		end
	end
endmodule : erfp_port

// [erfp_top.sv]
// Error-management register space and per-port output fail policy.
// Assumes strobes from a same-clock master and same-clock queue events.
//
// Overview of operation
// - Header register carries feature identifier 0x0007.
// - Hard reset, self-reset and per-port reset restore reset values.
// - Boot-time serial loading may override writable reset values.
// - Powered-down port ignores writes and reads zero.
// - Bus and transport errors set detect bit 0; capture holds info.
// - Every register is one aligned 32-bit word.
// - Shared registers start at 0x1000.
// - Port blocks at 0x1040 step 0x40 to 0x1400; even ports wide.
// - Threshold behaviour chosen by stop and drop enable bits.
// - Both bits clear: keep transmitting despite failure.
// - Drop only: discard rejected packets, flag each drop.
// - Drop only: below threshold again, forward normally.
// - Stop only: cease transmission while failed, queue congests.
// - Both bits: discard without sending, flag each drop.
// - Both bits: discard only packets queued at that moment.
// - Stop and drop enables are read-write, reset to zero.
module erfp_top
	import erfp_pkg::*;
#(
	parameter int NUM_PORTS = ERFP_NUM_PORTS
)(
	// Clock, enable, resets
	input wire logic clk,
	input wire logic ce,
	input wire logic sys_rst,
	input wire logic self_rst,
	input wire logic [NUM_PORTS-1:0] port_rst,
	// Boot load of writable fields
	input wire logic boot_we,
	input wire logic [erfp_pkg::ERFP_ADDR_W-1:0] boot_addr,
	input wire logic [erfp_pkg::ERFP_DATA_W-1:0] boot_wdata,
	// Register port
	input wire logic [erfp_pkg::ERFP_ADDR_W-1:0] reg_addr,
	input wire logic [erfp_pkg::ERFP_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [erfp_pkg::ERFP_DATA_W-1:0] reg_rdata,
	// Per-port error and link events
	input wire logic [NUM_PORTS-1:0] err_event,
	input wire logic [NUM_PORTS*erfp_pkg::ERFP_DATA_W-1:0] err_info,
	input wire logic [NUM_PORTS-1:0] rate_err,
	input wire logic [NUM_PORTS-1:0] rate_dec,
	input wire logic [NUM_PORTS-1:0] pkt_enq,
	input wire logic [NUM_PORTS-1:0] pkt_head,
	input wire logic [NUM_PORTS-1:0] pkt_nack,
	// Per-port decisions
	output logic [NUM_PORTS-1:0] tx_allow,
	output logic [NUM_PORTS-1:0] pkt_drop,
	// Interrupt
	output logic irq
);
	// Four-bit port index in the decode, so no more than sixteen ports
	if (NUM_PORTS < 1 || NUM_PORTS > ERFP_NUM_PORTS) begin : g_bad_ports
		$error("NUM_PORTS out of range");
	end

	////////////////////////////////////////////////////////////////////////
	logic hard_rst;
	logic [NUM_PORTS-1:0] pdown;
	logic [NUM_PORTS-1:0] irq_stat;
	logic [NUM_PORTS-1:0] irq_mask;
	logic [NUM_PORTS-1:0] drop_now;
	logic [NUM_PORTS-1:0] allow_now;
	logic [NUM_PORTS-1:0] hit_port;
	logic [NUM_PORTS-1:0] drop_seen;
	logic in_ports;
	logic [15:0] port_off;
	logic [3:0] sel_port;
	logic [5:0] sel_ofs;
	logic [NUM_PORTS-1:0] detect;
	logic [ERFP_DATA_W-1:0] capture [NUM_PORTS];
	logic [NUM_PORTS-1:0] stop_fail_en;
	logic [NUM_PORTS-1:0] drop_en;
	logic [NUM_PORTS-1:0] out_failed;
	logic [NUM_PORTS-1:0] out_dropped;
	logic [ERFP_CNT_W-1:0] rate_cnt [NUM_PORTS];
	logic [ERFP_CNT_W-1:0] rate_thr [NUM_PORTS];
	logic [ERFP_DATA_W-1:0] next_rdata;

	assign hard_rst = sys_rst || self_rst;

	// Port decode; stride is a power of two so the word offset splits cleanly
	assign port_off = reg_addr - ERFP_PORT_BASE;
	assign in_ports = reg_addr >= ERFP_PORT_BASE && reg_addr < ERFP_PORT_LAST + ERFP_PORT_STRIDE;
	assign sel_port = port_off[9:6];
	assign sel_ofs = {port_off[5:2], 2'b00};
	assign hit_port = in_ports && sel_port < NUM_PORTS ? NUM_PORTS'(1) << sel_port : '0;

	////////////////////////////////////////////////////////////////////////
	// Per-port registers
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			logic prst;
			logic wr_here;
			logic boot_here;
			logic [15:0] pbase;

			assign pbase = ERFP_PORT_BASE + 16'(p) * ERFP_PORT_STRIDE;
			assign prst = hard_rst || port_rst[p];
			// Powered-down port drops writes
			assign wr_here = reg_wr && hit_port[p] && !pdown[p];
			assign boot_here = boot_we && boot_addr == pbase + 16'(ERFP_OFS_STATUS);

			always_ff @(posedge clk) begin
				if (prst) begin
					detect[p] <= 1'b0;
					capture[p] <= ERFP_RST_ZERO;
				end else if (ce) begin
					if (err_event[p] && !detect[p]) begin
						detect[p] <= 1'b1;
						capture[p] <= err_info[p*ERFP_DATA_W +: ERFP_DATA_W];
					end else if (wr_here && sel_ofs == ERFP_OFS_DETECT) begin
						detect[p] <= reg_wdata[ERFP_BIT_DETECT];
					end else if (wr_here && sel_ofs == ERFP_OFS_CAPTURE && !detect[p]) begin
						capture[p] <= reg_wdata;
					end
				end
			end

			always_ff @(posedge clk) begin
				if (prst) begin
					stop_fail_en[p] <= 1'b0;
					drop_en[p] <= 1'b0;
				end else if (ce) begin
					if (boot_here) begin
						stop_fail_en[p] <= boot_wdata[ERFP_BIT_STOP_FAIL];
						drop_en[p] <= boot_wdata[ERFP_BIT_DROP_EN];
					end else if (wr_here && sel_ofs == ERFP_OFS_STATUS) begin
						stop_fail_en[p] <= reg_wdata[ERFP_BIT_STOP_FAIL];
						drop_en[p] <= reg_wdata[ERFP_BIT_DROP_EN];
					end
				end
			end

			// Sticky status bits: hardware set wins over write-one-clear
			always_ff @(posedge clk) begin
				if (prst) begin
					out_failed[p] <= 1'b0;
					out_dropped[p] <= 1'b0;
				end else if (ce) begin
					if (rate_cnt[p] >= rate_thr[p])
						out_failed[p] <= 1'b1;
					else if (wr_here && sel_ofs == ERFP_OFS_STATUS && reg_wdata[ERFP_BIT_OUT_FAILED])
						out_failed[p] <= 1'b0;
					if (drop_now[p])
						out_dropped[p] <= 1'b1;
					else if (wr_here && sel_ofs == ERFP_OFS_STATUS && reg_wdata[ERFP_BIT_OUT_DROPPED])
						out_dropped[p] <= 1'b0;
				end
			end

			// Error-rate counter: saturating, leaks down on decay events
			always_ff @(posedge clk) begin
				if (prst) begin
					rate_cnt[p] <= '0;
					rate_thr[p] <= ERFP_RST_THRESHOLD;
				end else if (ce) begin
					if (boot_we && boot_addr == pbase + 16'(ERFP_OFS_RATE))
						rate_thr[p] <= boot_wdata[ERFP_RATE_THR_LSB +: ERFP_CNT_W];
					else if (wr_here && sel_ofs == ERFP_OFS_RATE) begin
						rate_thr[p] <= reg_wdata[ERFP_RATE_THR_LSB +: ERFP_CNT_W];
						rate_cnt[p] <= reg_wdata[ERFP_RATE_CNT_LSB +: ERFP_CNT_W];
					end
					if (!(wr_here && sel_ofs == ERFP_OFS_RATE)) begin
						if (rate_err[p] && !rate_dec[p] && rate_cnt[p] != '1)
							rate_cnt[p] <= rate_cnt[p] + 1'b1;
						else if (rate_dec[p] && !rate_err[p] && rate_cnt[p] != '0)
							rate_cnt[p] <= rate_cnt[p] - 1'b1;
					end
				end
			end

			erfp_port u_port (
				.clk(clk),
				.ce(ce),
				.rst(prst),
				.stop_fail_en(stop_fail_en[p]),
				.drop_en(drop_en[p]),
				.output_failed(out_failed[p]),
				.threshold_hit(rate_cnt[p] >= rate_thr[p]),
				.pkt_enq(pkt_enq[p]),
				.pkt_head(pkt_head[p]),
				.pkt_nack(pkt_nack[p]),
				.tx_allow(allow_now[p]),
				.drop_pulse(drop_now[p])
			);

			// Capture event, not the detect level, so a write-one clear can stick
			assign drop_seen[p] = drop_now[p] || (err_event[p] && !detect[p]);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Registered decisions
	always_ff @(posedge clk) begin
		if (hard_rst) begin
			tx_allow <= '0;
			pkt_drop <= '0;
		end else if (ce) begin
			tx_allow <= allow_now & ~pdown;
			pkt_drop <= drop_now;
		end
	end

	// Power-down and interrupt control
	always_ff @(posedge clk) begin
		if (hard_rst) begin
			pdown <= '0;
			irq_mask <= '0;
		end else if (ce && reg_wr) begin
			if (reg_addr == ERFP_PDOWN)
				pdown <= reg_wdata[NUM_PORTS-1:0];
			if (reg_addr == ERFP_IRQ_MASK)
				irq_mask <= reg_wdata[NUM_PORTS-1:0];
		end
	end

	// Event set wins over write-one-clear
	always_ff @(posedge clk) begin
		if (hard_rst)
			irq_stat <= '0;
		else if (ce)
			irq_stat <= drop_seen | (irq_stat & ~(reg_wr && reg_addr == ERFP_IRQ_STAT ?
				reg_wdata[NUM_PORTS-1:0] : '0));
	end

	always_ff @(posedge clk) begin
		if (hard_rst)
			irq <= 1'b0;
		else if (ce)
			irq <= |(irq_stat & irq_mask);
	end

	////////////////////////////////////////////////////////////////////////
	// Read path; unmapped and reserved words read zero
	always_comb begin
		next_rdata = '0;
		if (reg_addr == ERFP_GEN_HEADER)
			next_rdata = {ERFP_NEXT_PTR, ERFP_FEATURE_ID};
		else if (reg_addr == ERFP_IRQ_STAT)
			next_rdata = ERFP_DATA_W'(irq_stat);
		else if (reg_addr == ERFP_IRQ_MASK)
			next_rdata = ERFP_DATA_W'(irq_mask);
		else if (reg_addr == ERFP_PDOWN)
			next_rdata = ERFP_DATA_W'(pdown);
		else if (|hit_port && !pdown[sel_port]) begin
			case (sel_ofs)
				ERFP_OFS_DETECT: next_rdata[ERFP_BIT_DETECT] = detect[sel_port];
				ERFP_OFS_CAPTURE: next_rdata = capture[sel_port];
				ERFP_OFS_STATUS: begin
					next_rdata[ERFP_BIT_OUT_FAILED] = out_failed[sel_port];
					next_rdata[ERFP_BIT_OUT_DROPPED] = out_dropped[sel_port];
					next_rdata[ERFP_BIT_STOP_FAIL] = stop_fail_en[sel_port];
					next_rdata[ERFP_BIT_DROP_EN] = drop_en[sel_port];
					next_rdata[ERFP_BIT_WIDE_PORT] = ~sel_port[0];
				end
				ERFP_OFS_RATE: begin
					next_rdata[ERFP_RATE_CNT_LSB +: ERFP_CNT_W] = rate_cnt[sel_port];
					next_rdata[ERFP_RATE_THR_LSB +: ERFP_CNT_W] = rate_thr[sel_port];
				end
				default: next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (hard_rst)
			reg_rdata <= '0;
		else if (ce)
			reg_rdata <= reg_rd ? next_rdata : '0;
	end
endmodule : erfp_top

// [erfp_top_properties.sv]
// Port-level timing checks for the error-management block.
// Assumes a bind onto erfp_top and one clk domain.
module erfp_top_properties
	import erfp_pkg::*;
#(
	parameter int NUM_PORTS = ERFP_NUM_PORTS
)(
	// Clock and resets
	input wire logic clk,
	input wire logic ce,
	input wire logic sys_rst,
	input wire logic self_rst,
	// Register port
	input wire logic [erfp_pkg::ERFP_ADDR_W-1:0] reg_addr,
	input wire logic [erfp_pkg::ERFP_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [erfp_pkg::ERFP_DATA_W-1:0] reg_rdata,
	// Decisions
	input wire logic [NUM_PORTS-1:0] tx_allow,
	input wire logic [NUM_PORTS-1:0] pkt_drop,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_read_slot_only: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside its slot");
	a_header_value: assert property (reg_rd && ce && reg_addr == ERFP_GEN_HEADER
		|=> reg_rdata == {ERFP_NEXT_PTR, ERFP_FEATURE_ID}) else $error("header word wrong");
	a_below_map_zero: assert property (reg_rd && ce && reg_addr < ERFP_GEN_BASE |=> reg_rdata == '0)
		else $error("read below map not zero");
	a_reset_quiet: assert property ($fell(sys_rst) |-> tx_allow == '0 && pkt_drop == '0 && !irq)
		else $error("outputs active after reset");
	a_self_reset_quiet: assert property (self_rst && ce |=> pkt_drop == '0 && !irq)
		else $error("outputs active after self reset");
	a_narrow_port_type: assert property (reg_rd && ce && reg_addr >= ERFP_PORT_BASE && !reg_addr[6]
		&& reg_addr < 16'h1440 && reg_addr[5:0] == ERFP_OFS_STATUS |=> !reg_rdata[ERFP_BIT_WIDE_PORT])
		else $error("odd port reads as wide");
	a_hold_freezes: assert property (!ce |=> $stable(tx_allow) && $stable(irq))
		else $error("state moved with enable low");
	a_pdown_readback: assert property (reg_wr && ce && reg_addr == ERFP_PDOWN ##1 !reg_wr
		##1 reg_rd && ce && reg_addr == ERFP_PDOWN
		|=> reg_rdata[NUM_PORTS-1:0] == $past(reg_wdata[NUM_PORTS-1:0], 3)) else $error("power-down readback");
endmodule // erfp_top_properties

// [erfp_link_partner.sv]
// Link partner model: accepts or refuses each packet sent to it.
// Assumes head pulses from the bench and tx_allow from the ports.
module erfp_link_partner
	import erfp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Link side
	input wire logic [erfp_pkg::ERFP_NUM_PORTS-1:0] tx_allow,
	input wire logic [erfp_pkg::ERFP_NUM_PORTS-1:0] pkt_head,
	input wire logic [erfp_pkg::ERFP_NUM_PORTS-1:0] reject,
	output logic [erfp_pkg::ERFP_NUM_PORTS-1:0] pkt_nack
);
	// Held ports send nothing, so nothing there can be refused
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pkt_nack <= '0;
		end else begin
			pkt_nack <= pkt_head & tx_allow & reject;
		end
	end
endmodule // erfp_link_partner

// [test_erfp_top.sv]
// Testbench for erfp_top: register map, resets and fail-policy modes.
// Assumes the link partner model and the bound property checker.
module test_erfp_top;
	timeunit 1ns;
	timeprecision 1ps;
	import erfp_pkg::*;
	logic clk = 1'b0, ce = 1'b1, sys_rst = 1'b1, self_rst = 1'b0, boot_we = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [15:0] port_rst = '0, err_event = '0, rate_err = '0, rate_dec = '0, pkt_enq = '0, pkt_head = '0;
	logic [15:0] reject = '0, boot_addr = '0, reg_addr = '0, pkt_nack, tx_allow, pkt_drop;
	logic [31:0] boot_wdata = '0, reg_wdata = '0, reg_rdata;
	logic [511:0] err_info = {16{32'h1234_abcd}};
	logic irq, irq_a;
	int n_errors = 0, n_compared = 0, n_drop = 0, wp = 0;

	erfp_top erfp_top_inst (.clk, .ce, .sys_rst, .self_rst, .port_rst, .boot_we, .boot_addr, .boot_wdata, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .err_event, .err_info, .rate_err, .rate_dec, .pkt_enq, .pkt_head,
		.pkt_nack, .tx_allow, .pkt_drop, .irq);
	erfp_link_partner erfp_link_partner_inst (.clk, .sys_rst, .tx_allow, .pkt_head, .reject, .pkt_nack);

	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		if (pkt_drop[wp] === 1'b1) n_drop++;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		wrap_up();
	end
	////////////////////////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Word-aligned port block address
	function automatic logic [15:0] pa(input int p, input logic [5:0] o);
		return 16'h1040 + 16'(p) * 16'h0040 + {10'h0, o};
	endfunction
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	// One-cycle event pulse on port p
	task automatic ev(input int k, input int p);
		@(posedge clk);
		case (k)
			0: rate_err[p] <= 1'b1;
			1: rate_dec[p] <= 1'b1;
			2: pkt_enq[p] <= 1'b1;
			3: pkt_head[p] <= 1'b1;
			default: err_event[p] <= 1'b1;
		endcase
		@(posedge clk);
		{rate_err, rate_dec, pkt_enq, pkt_head, err_event} <= '0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		rd(ERFP_GEN_HEADER, 32'h0000_0007);
		rd(16'h0ff0, '0);
		for (int p = 0; p < 16; p++) begin
			rd(pa(p, ERFP_OFS_STATUS), {~p[0], 31'h0});
		end
		rd(pa(0, ERFP_OFS_RATE), 32'h00ff_0000);
		wr(pa(0, ERFP_OFS_STATUS), 32'h3000_0000);
		wr(pa(2, ERFP_OFS_STATUS), 32'h3000_0000);
		rd(pa(0, ERFP_OFS_STATUS), 32'hb000_0000);
		@(posedge clk);
		port_rst <= 16'h0001;
		@(posedge clk);
		port_rst <= '0;
		rd(pa(0, ERFP_OFS_STATUS), 32'h8000_0000);
		rd(pa(2, ERFP_OFS_STATUS), 32'hb000_0000);
		@(posedge clk);
		self_rst <= 1'b1;
		@(posedge clk);
		self_rst <= 1'b0;
		rd(pa(2, ERFP_OFS_STATUS), 32'h8000_0000);
		@(posedge clk);
		{boot_we, boot_addr, boot_wdata} <= {1'b1, pa(1, ERFP_OFS_STATUS), 32'h2000_0000};
		@(posedge clk);
		{boot_addr, boot_wdata} <= {pa(5, ERFP_OFS_RATE), 32'h0040_0000};
		@(posedge clk);
		boot_we <= 1'b0;
		rd(pa(1, ERFP_OFS_STATUS), 32'h2000_0000);
		rd(pa(5, ERFP_OFS_RATE), 32'h0040_0000);
		wr(ERFP_PDOWN, 32'h0000_0004);
		rd(ERFP_PDOWN, 32'h0000_0004);
		wr(pa(2, ERFP_OFS_STATUS), 32'h3000_0000);
		rd(pa(2, ERFP_OFS_STATUS), '0);
		wr(ERFP_PDOWN, '0);
		rd(pa(2, ERFP_OFS_STATUS), 32'h8000_0000);
		ev(4, 3);
		rd(pa(3, ERFP_OFS_DETECT), 32'h0000_0001);
		rd(pa(3, ERFP_OFS_CAPTURE), 32'h1234_abcd);
		rd(ERFP_IRQ_STAT, 32'h0000_0008);
		wr(ERFP_IRQ_MASK, 32'h0000_ffff);
		settle(2);
		irq_a = irq;
		wr(ERFP_IRQ_MASK, '0);
		settle(2);
		chk({31'h0, irq ^ irq_a}, 32'h1);
		wr(ERFP_IRQ_MASK, 32'h0000_ffff);
		wr(ERFP_IRQ_STAT, 32'h0000_0008);
		settle(2);
		chk({31'h0, irq}, '0);
		rd(ERFP_IRQ_STAT, '0);
		@(posedge clk);
		ce <= 1'b0;
		wr(ERFP_PDOWN, 32'h0000_0010);
		ce <= 1'b1;
		rd(ERFP_PDOWN, '0);
		// Drop only, then both clear and stop only, threshold of two errors
		wp = 4;
		reject <= '1;
		wr(pa(4, ERFP_OFS_RATE), 32'h0002_0000);
		wr(pa(4, ERFP_OFS_STATUS), 32'h2000_0000);
		ev(0, 4);
		ev(0, 4);
		n_drop = 0;
		ev(3, 4);
		settle(4);
		chk(n_drop, 1);
		rd(pa(4, ERFP_OFS_STATUS), 32'ha500_0000);
		ev(1, 4);
		n_drop = 0;
		ev(3, 4);
		settle(4);
		chk(n_drop, 0);
		wr(pa(4, ERFP_OFS_STATUS), '0);
		ev(0, 4);
		ev(3, 4);
		settle(4);
		chk({31'h0, tx_allow[4]}, 1);
		chk(n_drop, 0);
		wr(pa(4, ERFP_OFS_STATUS), 32'h1000_0000);
		settle(2);
		chk({31'h0, tx_allow[4]}, 0);
		// Both bits: three packets queued before failure onset
		wp = 6;
		wr(pa(6, ERFP_OFS_RATE), 32'h0002_0000);
		ev(0, 6);
		repeat (3) ev(2, 6);
		wr(pa(6, ERFP_OFS_STATUS), 32'h3000_0000);
		n_drop = 0;
		ev(0, 6);
		settle(2);
		repeat (3) ev(3, 6);
		settle(12);
		chk(n_drop, 3);
		rd(pa(6, ERFP_OFS_STATUS), 32'hb500_0000);
		reject <= '0;
		n_drop = 0;
		ev(2, 6);
		ev(3, 6);
		settle(4);
		chk(n_drop, 0);
		chk({31'h0, tx_allow[6]}, 1);
		wrap_up();
	end
endmodule // test_erfp_top

bind erfp_top erfp_top_properties #(.NUM_PORTS(NUM_PORTS)) erfp_top_properties_inst (.clk, .ce, .sys_rst, .self_rst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_allow, .pkt_drop, .irq);
